// *** core/lip_cfg.svh ***
`ifndef LIP_CFG_SVH
`define LIP_CFG_SVH

// Register byte offsets
`define LIP_OFS_MASTER_CONFIG_ONE    5'h00
`define LIP_OFS_LINE_POLARITY_CONFIG 5'h04
`define LIP_OFS_BPV_COUNT_LOW        5'h08
`define LIP_OFS_BPV_COUNT_HIGH       5'h0c
`define LIP_OFS_IRQ_STATUS           5'h10
`define LIP_OFS_IRQ_MASK             5'h14
`define LIP_OFS_LIVE_STATUS          5'h18

// master_config_one fields
`define LIP_CB_SINGLE_RAIL  0
`define LIP_CB_FALLBACK     1
`define LIP_CB_LINE_LOOP    2
`define LIP_CB_PAYLOAD_LOOP 3

// line_polarity_config fields
`define LIP_PB_TX_CLK_INV 0
`define LIP_PB_RX_CLK_INV 1
`define LIP_PB_TX_POS_HI  2
`define LIP_PB_TX_POS_INV 3
`define LIP_PB_TX_NEG_HI  4
`define LIP_PB_TX_NEG_INV 5
`define LIP_PB_RX_POS_INV 6
`define LIP_PB_RX_NEG_INV 7

// Interrupt status and live status fields
`define LIP_SB_TX_LOSS  0
`define LIP_SB_VIOL     1
`define LIP_SB_BPV_WRAP 2
`define LIP_ST_W        3
`define LIP_LIVE_TX_LOST 0

// Widths and reset values
`define LIP_REG_W   8
`define LIP_REG_RST 8'h00
`define LIP_ST_RST  3'h0
`define LIP_BPV_W   16
`define LIP_BPV_RST 16'h0000
`define LIP_LOSS_W  16
`define LIP_LOSS_RST 16'h0000

// Timing
`define LIP_MCLK_NS    10
`define LIP_TX_LOSS_NS 640
`define LIP_TX_LOSS_CYC ((`LIP_TX_LOSS_NS + `LIP_MCLK_NS - 1) / `LIP_MCLK_NS)

`endif

// *** core/lip_pkg.sv ***
`include "lip_cfg.svh"
package lip_pkg;

  typedef struct packed {
    logic [2:0] clkSync;
    logic [1:0] posSync;
    logic [1:0] negSync;
    logic       strobe;
    logic       posBit;
    logic       negBit;
    logic       violation;
  } lip_rx_state_t;

  typedef struct packed {
    logic [`LIP_REG_W-1:0]  masterConfigOne;
    logic [`LIP_REG_W-1:0]  linePolarityConfig;
    logic [`LIP_BPV_W-1:0]  bpvCount;
    logic [`LIP_ST_W-1:0]   irqStatus;
    logic [`LIP_ST_W-1:0]   irqMask;
    logic [2:0]             txClk;
    logic [`LIP_LOSS_W-1:0] lossCount;
    logic                   txLost;
    logic                   srcPrev;
    logic                   clkOut;
    logic                   rawPos;
    logic                   rawNeg;
    logic                   lastNeg;
    logic                   posOut;
    logic                   negOut;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   irq;
  } lip_main_state_t;

endpackage

// *** core/lip_rx_if.sv ***
`timescale 1ns/1ns
interface lip_rx_if;
  logic singleRail;
  logic rxClockInvert;
  logic rxPositiveInvert;
  logic rxNegativeInvert;
  logic bitStrobe;
  logic posBit;
  logic negBit;
  logic violation;
  logic clockLevel;

  modport control (
    output singleRail, rxClockInvert, rxPositiveInvert, rxNegativeInvert,
    input  bitStrobe, posBit, negBit, violation, clockLevel
  );
  modport sampler (
    input  singleRail, rxClockInvert, rxPositiveInvert, rxNegativeInvert,
    output bitStrobe, posBit, negBit, violation, clockLevel
  );
endinterface

// *** core/lip_rx_sampler.sv ***
`timescale 1ns/1ns
`include "lip_cfg.svh"
module lip_rx_sampler (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Line pins
  input wire logic rxLineClock,
  input wire logic rxPositiveRailIn,
  input wire logic rxNegativeRailIn,
  // Towards the port core
  lip_rx_if.sampler rxBus
);

  lip_pkg::lip_rx_state_t stQ;
  lip_pkg::lip_rx_state_t stD;
  logic                   activeEdge;

  ////////////////////////////////////////////////////////////////////
  // Only the second sync stage feeds the edge finder
  always_comb begin
    stD = stQ;
    stD.clkSync = {stQ.clkSync[1:0], rxLineClock};
    stD.posSync = {stQ.posSync[0], rxPositiveRailIn};
    stD.negSync = {stQ.negSync[0], rxNegativeRailIn};
    // Gapped clocks are fine: only real edges strobe, idle gaps do nothing
    activeEdge = rxBus.rxClockInvert ? (~stQ.clkSync[1] & stQ.clkSync[2])
                                     : (stQ.clkSync[1] & ~stQ.clkSync[2]);
    stD.strobe    = activeEdge;
    stD.violation = 1'b0;
    if (activeEdge) begin
      stD.posBit    = stQ.posSync[1] ^ rxBus.rxPositiveInvert;
      stD.negBit    = stQ.negSync[1] ^ rxBus.rxNegativeInvert;
      // Inverted input counts low levels
      stD.violation = rxBus.singleRail & (stQ.negSync[1] ^ rxBus.rxNegativeInvert);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign rxBus.bitStrobe  = stQ.strobe;
  assign rxBus.posBit     = stQ.posBit;
  assign rxBus.negBit     = stQ.negBit;
  assign rxBus.violation  = stQ.violation;
  assign rxBus.clockLevel = stQ.clkSync[1];

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence riseSeen;
    stQ.clkSync[1] && !stQ.clkSync[2];
  endsequence

  sequence fallSeen;
    !stQ.clkSync[1] && stQ.clkSync[2];
  endsequence

  rx_rise_strobe_a: assert property ((riseSeen and !rxBus.rxClockInvert) |=> rxBus.bitStrobe)
    else $error("rx rising edge gave no strobe");
  rx_fall_strobe_a: assert property ((fallSeen and rxBus.rxClockInvert) |=> rxBus.bitStrobe)
    else $error("rx falling edge gave no strobe");
  rx_pos_invert_a: assert property (rxBus.bitStrobe |->
      rxBus.posBit == ($past(stQ.posSync[1]) ^ $past(rxBus.rxPositiveInvert)))
    else $error("rx positive bit polarity wrong");
  rx_neg_invert_a: assert property (rxBus.bitStrobe |->
      rxBus.negBit == ($past(stQ.negSync[1]) ^ $past(rxBus.rxNegativeInvert)))
    else $error("rx negative bit polarity wrong");
  rx_viol_high_a: assert property (
      (rxBus.bitStrobe && $past(rxBus.singleRail) && !$past(rxBus.rxNegativeInvert))
      |-> rxBus.violation == $past(stQ.negSync[1]))
    else $error("violation not flagged on high input");
  rx_viol_low_a: assert property (
      (rxBus.bitStrobe && $past(rxBus.singleRail) && $past(rxBus.rxNegativeInvert))
      |-> rxBus.violation == !$past(stQ.negSync[1]))
    else $error("violation not flagged on low input");

endmodule // lip_rx_sampler

// *** core/lip_line_port.sv ***
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "lip_cfg.svh"

// Summary of operation
// - Dual-rail transmit sends AMI: positive rail for plus pulses, negative for minus.
// - Single-rail transmit sends plain binary on the positive output, negative held low.
// - Transmit data changes on the line clock rising edge, or falling when inverted.
// - Positive force drives high, invert inverts, both together give constant low.
// - Negative force drives high, invert inverts, both together give constant low.
// - Normally the line clock output copies the transmit input clock, optionally inverted.
// - During line or payload loopback the line clock output copies the receive clock.
// - With input clock lost and fallback set, line clock output copies receive clock.
// - Dual-rail receive: outside unit marks plus and minus pulses on the two rails.
// - Binary receive: positive input carries data, negative input carries code violations.
// - Receive inputs sampled on receive clock rising edge, or falling when inverted.
// - Receive positive invert flips the data input polarity before use.
// - Receive negative invert flips the negative or violation input before use.
// - Binary mode, no invert: counter adds one per receive clock with violation high.
// - Binary mode, inverted: counter adds one per receive clock with violation low.
// - Receive side works with gapped or continuous receive clocks.
module lip_line_port #(
  parameter logic [`LIP_LOSS_W-1:0] LOSS_CYCLES = `LIP_LOSS_W'(`LIP_TX_LOSS_CYC)
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Transmit line pins
  input  wire logic        tx_input_clock,
  output logic             tx_positive_rail_out,
  output logic             tx_negative_rail_out,
  output logic             tx_line_clock_out,
  // Receive line pins
  input  wire logic        rx_line_clock,
  input  wire logic        rx_positive_rail_in,
  input  wire logic        rx_negative_rail_in,
  // Formatter side
  input  wire logic        txSerialData,
  output logic             txBitTaken,
  // Framer side
  output logic             rxBitStrobe,
  output logic             rxPosBit,
  output logic             rxNegBit
);

  lip_rx_if rxBus ();

  lip_rx_sampler u_sampler (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .rxLineClock      (rx_line_clock),
    .rxPositiveRailIn (rx_positive_rail_in),
    .rxNegativeRailIn (rx_negative_rail_in),
    .rxBus            (rxBus)
  );

  ////////////////////////////////////////////////////////////////////
  // Force wins over data; force plus invert gives a constant low
  function automatic logic railDrive(input logic raw, input logic hi, input logic inv);
    railDrive = hi ? ~inv : (raw ^ inv);
  endfunction

  function automatic logic regHit(input logic [4:0] addr, input logic [4:0] ofs);
    regHit = (addr == ofs);
  endfunction

  lip_pkg::lip_main_state_t stQ;
  lip_pkg::lip_main_state_t stD;

  logic                  singleRail;
  logic                  fallbackEn;
  logic                  loopActive;
  logic                  txClkInv;
  logic                  useRx;
  logic                  srcLevel;
  logic                  srcRise;
  logic                  txEdgeAny;
  logic                  wrAccept;
  logic                  bpvClear;
  logic [`LIP_ST_W-1:0]  stSet;
  logic [`LIP_ST_W-1:0]  stClr;
  logic [31:0]           rdMux;

  assign singleRail = stQ.masterConfigOne[`LIP_CB_SINGLE_RAIL];
  assign fallbackEn = stQ.masterConfigOne[`LIP_CB_FALLBACK];
  assign loopActive = stQ.masterConfigOne[`LIP_CB_LINE_LOOP]
                    | stQ.masterConfigOne[`LIP_CB_PAYLOAD_LOOP];
  assign txClkInv   = stQ.linePolarityConfig[`LIP_PB_TX_CLK_INV];

  assign rxBus.singleRail       = singleRail;
  assign rxBus.rxClockInvert    = stQ.linePolarityConfig[`LIP_PB_RX_CLK_INV];
  assign rxBus.rxPositiveInvert = stQ.linePolarityConfig[`LIP_PB_RX_POS_INV];
  assign rxBus.rxNegativeInvert = stQ.linePolarityConfig[`LIP_PB_RX_NEG_INV];

  ////////////////////////////////////////////////////////////////////
  // Read mux, sampled into the read data flop on the first request cycle
  always_comb begin
    rdMux = 32'h0000_0000;
    if (regHit(avs_address, `LIP_OFS_MASTER_CONFIG_ONE)) begin
      rdMux[`LIP_REG_W-1:0] = stQ.masterConfigOne;
    end else if (regHit(avs_address, `LIP_OFS_LINE_POLARITY_CONFIG)) begin
      rdMux[`LIP_REG_W-1:0] = stQ.linePolarityConfig;
    end else if (regHit(avs_address, `LIP_OFS_BPV_COUNT_LOW)) begin
      rdMux[`LIP_REG_W-1:0] = stQ.bpvCount[`LIP_REG_W-1:0];
    end else if (regHit(avs_address, `LIP_OFS_BPV_COUNT_HIGH)) begin
      rdMux[`LIP_REG_W-1:0] = stQ.bpvCount[`LIP_BPV_W-1:`LIP_REG_W];
    end else if (regHit(avs_address, `LIP_OFS_IRQ_STATUS)) begin
      rdMux[`LIP_ST_W-1:0] = stQ.irqStatus;
    end else if (regHit(avs_address, `LIP_OFS_IRQ_MASK)) begin
      rdMux[`LIP_ST_W-1:0] = stQ.irqMask;
    end else if (regHit(avs_address, `LIP_OFS_LIVE_STATUS)) begin
      rdMux[`LIP_LIVE_TX_LOST] = stQ.txLost;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    stD = stQ;

    // Transmit input clock: two sync stages, then a history bit
    stD.txClk = {stQ.txClk[1:0], tx_input_clock};
    txEdgeAny = stQ.txClk[1] ^ stQ.txClk[2];

    // Loss watchdog restarts on every input clock edge
    if (txEdgeAny) begin
      stD.lossCount = `LIP_LOSS_RST;
      stD.txLost    = 1'b0;
    end else if (stQ.lossCount != LOSS_CYCLES) begin
      stD.lossCount = stQ.lossCount + `LIP_LOSS_W'(1);
    end else begin
      stD.txLost = 1'b1;
    end

    // Source pick is not glitch free; a switch may cost one short bit
    useRx    = loopActive | (fallbackEn & stQ.txLost);
    srcLevel = useRx ? rxBus.clockLevel : stQ.txClk[1];
    srcRise  = srcLevel & ~stQ.srcPrev;
    stD.srcPrev = srcLevel;
    // Inverting the output clock moves data onto its falling edge
    stD.clkOut  = srcLevel ^ txClkInv;
    txBitTaken  = srcRise;

    if (srcRise) begin
      if (singleRail) begin
        stD.rawPos = txSerialData;
        stD.rawNeg = 1'b0;
      end else begin
        // Marks alternate; a mark takes exactly one rail
        stD.rawPos = txSerialData & stQ.lastNeg;
        stD.rawNeg = txSerialData & ~stQ.lastNeg;
        if (txSerialData) begin
          stD.lastNeg = ~stQ.lastNeg;
        end
      end
    end

    stD.posOut = railDrive(stD.rawPos,
                           stQ.linePolarityConfig[`LIP_PB_TX_POS_HI],
                           stQ.linePolarityConfig[`LIP_PB_TX_POS_INV]);
    stD.negOut = railDrive(stD.rawNeg & ~singleRail,
                           stQ.linePolarityConfig[`LIP_PB_TX_NEG_HI],
                           stQ.linePolarityConfig[`LIP_PB_TX_NEG_INV]);

    // Bus: one wait state, write lands on the edge that ends the cycle after the wait
    stD.ack  = (avs_read | avs_write) & ~stQ.ack;
    wrAccept = avs_write & stQ.ack & avs_byteenable[0];
    if (avs_read & ~stQ.ack) begin
      stD.rdata = rdMux;
    end

    stClr    = {`LIP_ST_W{1'b0}};
    bpvClear = 1'b0;
    if (wrAccept) begin
      if (regHit(avs_address, `LIP_OFS_MASTER_CONFIG_ONE)) begin
        stD.masterConfigOne = avs_writedata[`LIP_REG_W-1:0];
      end else if (regHit(avs_address, `LIP_OFS_LINE_POLARITY_CONFIG)) begin
        stD.linePolarityConfig = avs_writedata[`LIP_REG_W-1:0];
      end else if (regHit(avs_address, `LIP_OFS_BPV_COUNT_LOW)) begin
        bpvClear = 1'b1;
      end else if (regHit(avs_address, `LIP_OFS_BPV_COUNT_HIGH)) begin
        bpvClear = 1'b1;
      end else if (regHit(avs_address, `LIP_OFS_IRQ_STATUS)) begin
        stClr = avs_writedata[`LIP_ST_W-1:0];
      end else if (regHit(avs_address, `LIP_OFS_IRQ_MASK)) begin
        stD.irqMask = avs_writedata[`LIP_ST_W-1:0];
      end
    end

    // A violation in the clearing cycle still counts as one
    if (bpvClear) begin
      stD.bpvCount = `LIP_BPV_RST;
    end
    if (rxBus.violation) begin
      stD.bpvCount = stD.bpvCount + `LIP_BPV_W'(1);
    end

    stSet = {`LIP_ST_W{1'b0}};
    stSet[`LIP_SB_TX_LOSS]  = stD.txLost & ~stQ.txLost;
    stSet[`LIP_SB_VIOL]     = rxBus.violation;
    stSet[`LIP_SB_BPV_WRAP] = rxBus.violation & ~bpvClear & (&stQ.bpvCount);
    // Set beats clear so no event is lost
    stD.irqStatus = (stQ.irqStatus & ~stClr) | stSet;
    stD.irq       = |(stD.irqStatus & stD.irqMask);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stQ <= '0;
      stQ.lastNeg <= 1'b1;
    end else begin
      stQ <= stD;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign avs_readdata         = stQ.rdata;
  assign avs_waitrequest      = (avs_read | avs_write) & ~stQ.ack;
  assign irq                  = stQ.irq;
  assign tx_positive_rail_out = stQ.posOut;
  assign tx_negative_rail_out = stQ.negOut;
  assign tx_line_clock_out    = stQ.clkOut;
  assign rxBitStrobe          = rxBus.bitStrobe;
  assign rxPosBit             = rxBus.posBit;
  assign rxNegBit             = rxBus.negBit;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence railChange;
    $changed(stQ.rawPos) || $changed(stQ.rawNeg);
  endsequence

  sequence dualPlain;
    !singleRail && (stQ.linePolarityConfig[`LIP_PB_TX_NEG_INV:`LIP_PB_TX_POS_HI] == 4'h0);
  endsequence

  rail_exclusive_a: assert property (dualPlain |=> !(stQ.posOut && stQ.negOut))
    else $error("both transmit rails high in dual-rail mode");
  ami_alternate_a: assert property ((srcRise && txSerialData && !singleRail)
      |=> (stQ.rawPos == $past(stQ.lastNeg)) && (stQ.rawNeg == !$past(stQ.lastNeg)))
    else $error("mark did not alternate rails");
  binary_neg_low_a: assert property ((singleRail
      && (stQ.linePolarityConfig[`LIP_PB_TX_NEG_INV:`LIP_PB_TX_NEG_HI] == 2'h0))
      |=> !stQ.negOut)
    else $error("negative rail not low in binary mode");
  data_on_edge_a: assert property (railChange |-> $past(srcRise))
    else $error("transmit rail changed off the active edge");
  pos_force_a: assert property (stQ.linePolarityConfig[`LIP_PB_TX_POS_HI]
      |=> stQ.posOut == !$past(stQ.linePolarityConfig[`LIP_PB_TX_POS_INV]))
    else $error("positive force level wrong");
  neg_force_a: assert property (stQ.linePolarityConfig[`LIP_PB_TX_NEG_HI]
      |=> stQ.negOut == !$past(stQ.linePolarityConfig[`LIP_PB_TX_NEG_INV]))
    else $error("negative force level wrong");
  tx_clock_copy_a: assert property (!useRx |=> stQ.clkOut == $past(stQ.txClk[1] ^ txClkInv))
    else $error("line clock does not follow input clock");
  loop_clock_a: assert property (loopActive
      |=> stQ.clkOut == $past(rxBus.clockLevel ^ txClkInv))
    else $error("line clock does not follow receive clock in loopback");
  loss_clock_a: assert property ((fallbackEn && stQ.txLost)
      |=> stQ.clkOut == $past(rxBus.clockLevel ^ txClkInv))
    else $error("line clock did not fall back to receive clock");
  bpv_count_a: assert property ((rxBus.violation && !bpvClear)
      |=> stQ.bpvCount == `LIP_BPV_W'($past(stQ.bpvCount) + `LIP_BPV_W'(1)))
    else $error("violation counter did not advance");
  bus_answer_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("bus request not answered within one wait state");

endmodule // lip_line_port

// *** verif/lip_liu_model.sv ***
`timescale 1ns/1ns
// Line unit stand-in: free running 160 ns clocks, receive clock gapped every fifth period
module lip_liu_model (
  // Controls from the bench
  input  wire logic txClkOn,
  input  wire logic rxPosVal,
  input  wire logic rxNegVal,
  // Line pins
  output logic      txInClk,
  output logic      rxClk,
  output logic      rxPos,
  output logic      rxNeg
);
  int n;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit input clock stands low while switched off
  initial begin
    txInClk = 1'b0;
    #17;
    forever begin
      #80;
      txInClk = txClkOn ? ~txInClk : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data moves a quarter period after the rise, so either sampling edge sees it settled
  initial begin
    rxClk = 1'b0;
    rxPos = 1'b0;
    rxNeg = 1'b0;
    n = 0;
    forever begin
      #40;
      rxPos = rxPosVal;
      rxNeg = rxNegVal;
      #40;
      rxClk = 1'b0;
      #80;
      rxClk = (n % 5) != 4;
      n++;
    end
  end
endmodule // lip_liu_model

// *** verif/test_line_interface_port.sv ***
`timescale 1ns/1ns
`include "lip_cfg.svh"
module test_line_interface_port;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        txInClk, txPos, txNeg, txLineClk, rxClk, rxPos, rxNeg;
  logic        txSerialData = 1'b0;
  logic        txBitTaken, rxBitStrobe, rxPosBit, rxNegBit;
  logic        txClkOn = 1'b1;
  logic        rxPosVal = 1'b0;
  logic        rxNegVal = 1'b0;
  int          numErrors = 0;
  int          samplesChecked = 0;
  int          taken;
  logic [14:0] r;
  logic [31:0] q;
  // Row: master config, polarity config, tx bit, rx positive, rx negative
  logic [14:0] rows [13] = '{
    {4'h0, 8'h00, 3'b010}, {4'h1, 8'h00, 3'b111}, {4'h1, 8'h80, 3'b101},
    {4'h1, 8'h80, 3'b100}, {4'h1, 8'h40, 3'b010}, {4'h1, 8'h04, 3'b000},
    {4'h1, 8'h0c, 3'b100}, {4'h1, 8'h08, 3'b100}, {4'h1, 8'h10, 3'b000},
    {4'h1, 8'h30, 3'b000}, {4'h1, 8'h20, 3'b000}, {4'h1, 8'h03, 3'b111},
    {4'h0, 8'h40, 3'b001}};
  logic [7:0]  srcSel [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
  logic [4:0]  regOfs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h1c};

  lip_line_port #(.LOSS_CYCLES(16'h0040)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .tx_input_clock(txInClk), .tx_positive_rail_out(txPos), .tx_negative_rail_out(txNeg),
    .tx_line_clock_out(txLineClk), .rx_line_clock(rxClk), .rx_positive_rail_in(rxPos),
    .rx_negative_rail_in(rxNeg), .txSerialData(txSerialData), .txBitTaken(txBitTaken),
    .rxBitStrobe(rxBitStrobe), .rxPosBit(rxPosBit), .rxNegBit(rxNegBit));

  lip_liu_model liu (
    .txClkOn(txClkOn), .rxPosVal(rxPosVal), .rxNegVal(rxNegVal), .txInClk(txInClk),
    .rxClk(rxClk), .rxPos(rxPos), .rxNeg(rxNeg));

  initial begin
    forever begin
      #5 mclk = ~mclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge, before that edge's updates land
  task automatic busXfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                         input logic [3:0] be, output logic [31:0] rd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] x;
    busXfer(1'b1, a, {24'h000000, d}, 4'hf, x);
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    busXfer(1'b0, a, 32'h0, 4'hf, x);
    check(x, e);
  endtask

  // Present one bit, wait until it is taken, then look at the line pins
  task automatic sendBit(input logic d, input logic ep, input logic en, input logic ec);
    int k;
    @(posedge mclk);
    txSerialData <= d;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (txBitTaken !== 1'b1 && k < 100);
    check(32'(txBitTaken), 32'h1);
    @(posedge mclk);
    #1;
    check(32'({txLineClk, txPos, txNeg}), 32'({ec, ep, en}));
  endtask

  task automatic waitStrobe(input int n);
    repeat (n) begin
      do @(negedge mclk); while (rxBitStrobe !== 1'b1);
    end
  endtask

  function automatic logic railOut(input logic raw, input logic hi, input logic inv);
    return (raw | hi) ^ inv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    numErrors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (regOfs[i]) rdChk(regOfs[i], 32'h0);
    sendBit(1'b1, 1'b1, 1'b0, 1'b1);
    sendBit(1'b1, 1'b0, 1'b1, 1'b1);
    sendBit(1'b0, 1'b0, 1'b0, 1'b1);
    sendBit(1'b1, 1'b1, 1'b0, 1'b1);
    foreach (rows[i]) begin
      r = rows[i];
      wr(`LIP_OFS_MASTER_CONFIG_ONE, {4'h0, r[14:11]});
      wr(`LIP_OFS_LINE_POLARITY_CONFIG, r[10:3]);
      rxPosVal <= r[1];
      rxNegVal <= r[0];
      sendBit(r[2], railOut(r[11] & r[2], r[5], r[6]), railOut(1'b0, r[7], r[8]), ~r[3]);
      waitStrobe(3);
      check(32'({rxPosBit, rxNegBit}), 32'({r[1] ^ r[9], r[0] ^ r[10]}));
      if (r[11]) begin
        // Clear right after a strobe so no violation lands in the clearing cycle
        waitStrobe(1);
        wr(`LIP_OFS_BPV_COUNT_LOW, 8'h00);
        waitStrobe(4);
        repeat (3) @(posedge mclk);
        rdChk(`LIP_OFS_BPV_COUNT_LOW, (r[0] ^ r[10]) ? 32'h4 : 32'h0);
        rdChk(`LIP_OFS_BPV_COUNT_HIGH, 32'h0);
      end
    end
    // Clock source selection with the transmit input clock stopped
    rxPosVal <= 1'b0;
    rxNegVal <= 1'b0;
    wr(`LIP_OFS_LINE_POLARITY_CONFIG, 8'h00);
    wr(`LIP_OFS_MASTER_CONFIG_ONE, 8'h00);
    wr(`LIP_OFS_IRQ_STATUS, 8'h07);
    wr(`LIP_OFS_IRQ_MASK, 8'h01);
    txClkOn <= 1'b0;
    repeat (10) @(posedge mclk);
    foreach (srcSel[i]) begin
      wr(`LIP_OFS_MASTER_CONFIG_ONE, srcSel[i]);
      taken = 0;
      repeat (120) begin
        @(negedge mclk);
        taken += int'(txBitTaken);
      end
      check(32'(taken != 0), 32'(srcSel[i] != 8'h00));
    end
    check(32'(irq), 32'h1);
    rdChk(`LIP_OFS_LIVE_STATUS, 32'h1);
    rdChk(`LIP_OFS_IRQ_STATUS, 32'h1);
    wr(`LIP_OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    check(32'(irq), 32'h0);
    wr(`LIP_OFS_IRQ_STATUS, 8'h01);
    rdChk(`LIP_OFS_IRQ_STATUS, 32'h0);
    // Refused writes: unmapped place and lane zero disabled
    wr(5'h1c, 8'hff);
    rdChk(5'h1c, 32'h0);
    busXfer(1'b1, `LIP_OFS_MASTER_CONFIG_ONE, 32'hff, 4'h0, q);
    rdChk(`LIP_OFS_MASTER_CONFIG_ONE, 32'h8);
    wr(`LIP_OFS_LINE_POLARITY_CONFIG, 8'ha5);
    rdChk(`LIP_OFS_LINE_POLARITY_CONFIG, 32'ha5);
    test_done();
  end
endmodule // test_line_interface_port
